/* File: lfs_params.svh */
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH

// instruction field positions, bit 31 of the word is the most significant bit
`define LFS_OPC_RNG     31:26
`define LFS_TGT_RNG     25:21
`define LFS_BASE_RNG    20:16
`define LFS_INDEX_RNG   15:11
`define LFS_DISP_RNG    15:0
`define LFS_XO_RNG      10:1
`define LFS_DISP_MSB    15

// opcode encodings
`define LFS_OPC_DISP    6'h30
`define LFS_OPC_DISPU   6'h31
`define LFS_OPC_EXT     6'h1F
`define LFS_XO_IDXU     10'h237
`define LFS_XO_IDX      10'h217

// register numbers
`define LFS_REG_ZERO    5'h00

// widening constants
`define LFS_SGL_EXP_MAX 8'hFF
`define LFS_SGL_EXP_0   8'h00
`define LFS_DBL_EXP_MAX 11'h7FF
`define LFS_BIAS_DIFF   11'h380
`define LFS_DENORM_BASE 11'h36A
`define LFS_FRAC_BITS   5'h17
`define LFS_FRAC_PAD    29'h0

`endif

/* File: lfs_pkg.sv */
package lfs_pkg;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    LFS_IDLE    = 5'h01,
    LFS_RDREG   = 5'h02,
    LFS_MEMREQ  = 5'h04,
    LFS_MEMWAIT = 5'h08,
    LFS_WRBACK  = 5'h10
  } lfs_state_t;

  // addressing form of the accepted load
  typedef enum logic [1:0] {
    LFS_FORM_DISP  = 2'h0,
    LFS_FORM_DISPU = 2'h1,
    LFS_FORM_IDXU  = 2'h2,
    LFS_FORM_IDX   = 2'h3
  } lfs_form_t;

endpackage : lfs_pkg

/* File: lfs_widen_if.sv */
`timescale 1ns/10ps
// carries a loaded single word to the widener and the double result back
interface lfs_widen_if;
  logic        load;          // capture single_word this cycle
  logic [31:0] single_word;   // raw loaded word
  logic [63:0] double_word;   // registered widened result
  modport feed (output load, output single_word, input double_word);
  modport conv (input load, input single_word, output double_word);
endinterface : lfs_widen_if

/* File: lfs_widen.sv */
`timescale 1ns/10ps
`include "lfs_params.svh"
module lfs_widen
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // data carrier
  lfs_widen_if.conv w
);

  // exact single to double widening; nan payloads keep their top bits
  function automatic logic [63:0] lfs_widen_word(input logic [31:0] s);
    logic [7:0]  e;
    logic [22:0] f;
    logic [10:0] e11;
    logic [22:0] fn;
    logic [4:0]  p;
    e   = s[30:23];
    f   = s[22:0];
    e11 = 11'h000;
    fn  = f;
    p   = 5'h00;
    if (e == `LFS_SGL_EXP_MAX)
      e11 = `LFS_DBL_EXP_MAX;                   // inf and nan
    else if (e != `LFS_SGL_EXP_0)
      e11 = {3'h0, e} + `LFS_BIAS_DIFF;         // normal: rebias
    else if (f != 23'h000000)
    begin
      // denormal single is a normal double: find the leading one
      for (int i = 0; i < 23; i++)
        if (f[i])
          p = i[4:0];
      e11 = {6'h00, p} + `LFS_DENORM_BASE;
      fn  = f << (`LFS_FRAC_BITS - p);          // hidden bit falls off the top
    end
    return {s[31], e11, fn, `LFS_FRAC_PAD};
  endfunction : lfs_widen_word

  logic [63:0] dbl_reg;   // widened word, held until the next load

  // widen on load, the result stands one cycle later
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      dbl_reg <= 64'h0;
    else if (w.load)
      dbl_reg <= lfs_widen_word(w.single_word);
  end

  assign w.double_word = dbl_reg;

  a_widen_one: assert property (@(posedge core_clk_in) disable iff (srst_in)
    w.load && w.single_word == 32'h3F800000 |=> w.double_word == 64'h3FF0000000000000)
    else $error("single one did not widen to double one");

  a_widen_sign: assert property (@(posedge core_clk_in) disable iff (srst_in)
    w.load |=> w.double_word[63] == $past(w.single_word[31]))
    else $error("sign lost in widening");

endmodule : lfs_widen

/* File: lfs_decode.sv */
`timescale 1ns/10ps
`include "lfs_params.svh"
module lfs_decode
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // instruction stream
  input  wire logic        instr_valid_in,
  input  wire logic [31:0] instr_in,
  output logic             ready_out,
  output logic             illegal_out,
  // integer register file read, data returns the cycle after rd_en
  output logic             int_rd_en_out,
  output logic [4:0]       int_rd_base_addr_out,
  output logic [4:0]       int_rd_index_addr_out,
  input  wire logic [31:0] int_rd_base_data_in,
  input  wire logic [31:0] int_rd_index_data_in,
  // data storage access
  output logic             mem_req_out,
  output logic [31:0]      mem_addr_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_data_in,
  input  wire logic        mem_align_err_in,
  input  wire logic        mem_dsi_err_in,
  // float register write
  output logic             float_wr_en_out,
  output logic [4:0]       float_wr_addr_out,
  output logic [63:0]      float_wr_data_out,
  // integer register write (base update)
  output logic             int_wr_en_out,
  output logic [4:0]       int_wr_addr_out,
  output logic [31:0]      int_wr_data_out,
  // access fault and status write strobes
  output logic             fault_out,
  output logic             fpscr_wr_en_out,
  output logic             cr0_wr_en_out
);

  lfs_pkg::lfs_state_t state_reg;       // sequencer state
  lfs_pkg::lfs_form_t  form_reg;        // form of the load in flight
  logic [4:0]          tgt_reg;         // float_target_field
  logic [4:0]          base_reg;        // base_reg_field
  logic [15:0]         disp_reg;        // raw displacement
  logic [31:0]         ea_reg;          // effective_address
  logic                err_reg;         // access raised a fault
  logic                match;           // current word is one of ours
  lfs_pkg::lfs_form_t  form_next;       // decoded form
  logic [31:0]         ea_next;         // address being formed
  lfs_widen_if         wif ();          // carrier to the widener

  // true for the update forms
  function automatic logic lfs_is_update(input lfs_pkg::lfs_form_t f);
    return (f == lfs_pkg::LFS_FORM_DISPU) || (f == lfs_pkg::LFS_FORM_IDXU);
  endfunction : lfs_is_update

  // true for the displacement forms
  function automatic logic lfs_is_disp(input lfs_pkg::lfs_form_t f);
    return (f == lfs_pkg::LFS_FORM_DISP) || (f == lfs_pkg::LFS_FORM_DISPU);
  endfunction : lfs_is_disp

  // opcode decode; bit 0 of the extended forms is ignored
  always_comb
  begin
    match     = 1'b1;
    form_next = lfs_pkg::LFS_FORM_DISP;
    if (instr_in[`LFS_OPC_RNG] == `LFS_OPC_DISP)
      form_next = lfs_pkg::LFS_FORM_DISP;
    else if (instr_in[`LFS_OPC_RNG] == `LFS_OPC_DISPU)
      form_next = lfs_pkg::LFS_FORM_DISPU;
    else if (instr_in[`LFS_OPC_RNG] == `LFS_OPC_EXT && instr_in[`LFS_XO_RNG] == `LFS_XO_IDXU)
      form_next = lfs_pkg::LFS_FORM_IDXU;
    else if (instr_in[`LFS_OPC_RNG] == `LFS_OPC_EXT && instr_in[`LFS_XO_RNG] == `LFS_XO_IDX)
      form_next = lfs_pkg::LFS_FORM_IDX;
    else
      match = 1'b0;
  end

  // effective address; a zero base field means no base, not register 0
  always_comb
  begin
    ea_next = 32'h0;
    if (lfs_is_disp(form_reg))
    begin
      ea_next = {{16{disp_reg[`LFS_DISP_MSB]}}, disp_reg};
      if (base_reg != `LFS_REG_ZERO)
        ea_next = ea_next + int_rd_base_data_in;
    end
    else
    begin
      ea_next = int_rd_index_data_in;
      if (base_reg != `LFS_REG_ZERO)
        ea_next = int_rd_base_data_in + int_rd_index_data_in;
    end
  end

  // sequencer: one load at a time, no overlap
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      state_reg <= lfs_pkg::LFS_IDLE;
    else
      case (state_reg)
        lfs_pkg::LFS_IDLE:
          if (instr_valid_in && ready_out && match)
            state_reg <= lfs_pkg::LFS_RDREG;
        lfs_pkg::LFS_RDREG:   state_reg <= lfs_pkg::LFS_MEMREQ;
        lfs_pkg::LFS_MEMREQ:  state_reg <= lfs_pkg::LFS_MEMWAIT;
        lfs_pkg::LFS_MEMWAIT:
          if (mem_ack_in)
            state_reg <= lfs_pkg::LFS_WRBACK;
        lfs_pkg::LFS_WRBACK:  state_reg <= lfs_pkg::LFS_IDLE;
        default:              state_reg <= lfs_pkg::LFS_IDLE;
      endcase
  end

  // capture instruction fields at acceptance
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      form_reg <= lfs_pkg::LFS_FORM_DISP;
      tgt_reg  <= 5'h00;
      base_reg <= 5'h00;
      disp_reg <= 16'h0000;
    end
    else if (state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out && match)
    begin
      form_reg <= form_next;
      tgt_reg  <= instr_in[`LFS_TGT_RNG];
      base_reg <= instr_in[`LFS_BASE_RNG];
      disp_reg <= instr_in[`LFS_DISP_RNG];
    end
  end

  // ready drops while a load is in flight; undecodable words flag illegal
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ready_out   <= 1'b1;
      illegal_out <= 1'b0;
    end
    else
    begin
      illegal_out <= (state_reg == lfs_pkg::LFS_IDLE) && instr_valid_in && ready_out && !match;
      if (state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out && match)
        ready_out <= 1'b0;
      else if (state_reg == lfs_pkg::LFS_WRBACK)
        ready_out <= 1'b1;
    end
  end

  // integer register read, one cycle wide
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      int_rd_en_out         <= 1'b0;
      int_rd_base_addr_out  <= 5'h00;
      int_rd_index_addr_out <= 5'h00;
    end
    else
    begin
      int_rd_en_out <= (state_reg == lfs_pkg::LFS_IDLE) && instr_valid_in && ready_out && match;
      if (state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out && match)
      begin
        int_rd_base_addr_out  <= instr_in[`LFS_BASE_RNG];
        int_rd_index_addr_out <= instr_in[`LFS_INDEX_RNG];
      end
    end
  end

  // storage request held until acknowledged; fault recorded with the ack
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      mem_req_out  <= 1'b0;
      mem_addr_out <= 32'h0;
      ea_reg       <= 32'h0;
      err_reg      <= 1'b0;
    end
    else if (state_reg == lfs_pkg::LFS_MEMREQ)
    begin
      mem_req_out  <= 1'b1;
      mem_addr_out <= ea_next;
      ea_reg       <= ea_next;
    end
    else if (state_reg == lfs_pkg::LFS_MEMWAIT && mem_ack_in)
    begin
      mem_req_out <= 1'b0;
      err_reg     <= mem_align_err_in || mem_dsi_err_in;
    end
  end

  // loaded word goes to the widener on the ack
  assign wif.load        = (state_reg == lfs_pkg::LFS_MEMWAIT) && mem_ack_in;
  assign wif.single_word = mem_data_in;

  lfs_widen u_widen
  (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .w           (wif)
  );

  // write-back strobes, one cycle each
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      float_wr_en_out   <= 1'b0;
      float_wr_addr_out <= 5'h00;
      float_wr_data_out <= 64'h0;
      int_wr_en_out     <= 1'b0;
      int_wr_addr_out   <= 5'h00;
      int_wr_data_out   <= 32'h0;
      fault_out         <= 1'b0;
    end
    else
    begin
      float_wr_en_out <= (state_reg == lfs_pkg::LFS_WRBACK) && !err_reg;
      // base update only for update forms, nonzero base and a clean access
      int_wr_en_out   <= (state_reg == lfs_pkg::LFS_WRBACK) && !err_reg
                         && lfs_is_update(form_reg) && base_reg != `LFS_REG_ZERO;
      fault_out       <= (state_reg == lfs_pkg::LFS_WRBACK) && err_reg;
      if (state_reg == lfs_pkg::LFS_WRBACK)
      begin
        float_wr_addr_out <= tgt_reg;
        float_wr_data_out <= wif.double_word;
        int_wr_addr_out   <= base_reg;
        int_wr_data_out   <= ea_reg;
      end
    end
  end

  // these loads never touch status or condition fields
  always_ff @(posedge core_clk_in)
  begin
    fpscr_wr_en_out <= 1'b0;
    cr0_wr_en_out   <= 1'b0;
  end

  a_disp_decode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out
    && instr_in[`LFS_OPC_RNG] == `LFS_OPC_DISP
    |=> form_reg == lfs_pkg::LFS_FORM_DISP && tgt_reg == $past(instr_in[`LFS_TGT_RNG])
        && int_rd_en_out)
    else $error("displacement load not decoded");

  a_dispu_decode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out
    && instr_in[`LFS_OPC_RNG] == `LFS_OPC_DISPU
    |=> form_reg == lfs_pkg::LFS_FORM_DISPU && disp_reg == $past(instr_in[`LFS_DISP_RNG]))
    else $error("displacement update load not decoded");

  a_idxu_decode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out
    && instr_in[`LFS_OPC_RNG] == `LFS_OPC_EXT && instr_in[`LFS_XO_RNG] == `LFS_XO_IDXU
    |=> form_reg == lfs_pkg::LFS_FORM_IDXU && base_reg == $past(instr_in[`LFS_BASE_RNG]))
    else $error("indexed update load not decoded");

  a_idx_decode: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_IDLE && instr_valid_in && ready_out
    && instr_in[`LFS_OPC_RNG] == `LFS_OPC_EXT && instr_in[`LFS_XO_RNG] == `LFS_XO_IDX
    |=> form_reg == lfs_pkg::LFS_FORM_IDX
        && int_rd_index_addr_out == $past(instr_in[`LFS_INDEX_RNG]))
    else $error("indexed load not decoded");

  a_ea_disp: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_MEMREQ && lfs_is_disp(form_reg)
    |=> mem_req_out && mem_addr_out == {{16{$past(disp_reg[15])}}, $past(disp_reg)}
        + ($past(base_reg) == 5'h00 ? 32'h0 : $past(int_rd_base_data_in)))
    else $error("displacement address wrong");

  a_ea_index: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_MEMREQ && !lfs_is_disp(form_reg)
    |=> mem_addr_out == $past(int_rd_index_data_in)
        + ($past(base_reg) == 5'h00 ? 32'h0 : $past(int_rd_base_data_in)))
    else $error("indexed address wrong");

  a_float_write: assert property (@(posedge core_clk_in) disable iff (srst_in)
    state_reg == lfs_pkg::LFS_MEMWAIT && mem_ack_in && !mem_align_err_in && !mem_dsi_err_in
    |=> ##1 float_wr_en_out && float_wr_addr_out == tgt_reg)
    else $error("float target not written");

  a_update_cond: assert property (@(posedge core_clk_in) disable iff (srst_in)
    int_wr_en_out |-> int_wr_addr_out != 5'h00 && int_wr_data_out == ea_reg
                      && !fault_out && !$past(err_reg))
    else $error("base update under wrong condition");

  a_no_base_wr: assert property (@(posedge core_clk_in) disable iff (srst_in)
    int_wr_en_out |-> lfs_is_update(form_reg))
    else $error("non-update form wrote base");

  a_status_quiet: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !fpscr_wr_en_out && !cr0_wr_en_out)
    else $error("status field written");

endmodule : lfs_decode

/* File: lfs_env_model.sv */
`timescale 1ns/10ps
// stands in for the integer register file and the data storage path around the decoder
module lfs_env_model
(
  // clock
  input  wire logic        core_clk_in,
  // integer register file read
  input  wire logic        int_rd_en_in,
  input  wire logic [4:0]  int_rd_base_addr_in,
  input  wire logic [4:0]  int_rd_index_addr_in,
  output logic      [31:0] int_rd_base_data_out,
  output logic      [31:0] int_rd_index_data_out,
  // storage access and what the bench wants it to answer
  input  wire logic        mem_req_in,
  input  wire logic [31:0] mem_word_in,
  input  wire logic [1:0]  mem_wait_in,
  input  wire logic        align_fault_in,
  input  wire logic        dsi_fault_in,
  output logic             mem_ack_out,
  output logic      [31:0] mem_data_out,
  output logic             mem_align_err_out,
  output logic             mem_dsi_err_out
);
  logic [31:0] int_reg_file [32]; // contents are set by the bench
  logic        rd_hit;            // read request seen at this edge
  logic [4:0]  base_sel;          // captured base address
  logic [4:0]  index_sel;         // captured index address
  logic [1:0]  wait_cnt;          // cycles the request has waited

  // one process: read data lives for one cycle, then the lines flip so stale values never match
  initial
  begin
    int_rd_base_data_out = 32'h5A5A_5A5A;
    int_rd_index_data_out = 32'hA5A5_A5A5;
    mem_ack_out = 1'b0;
    wait_cnt = 2'h0;
    forever
    begin
      @(posedge core_clk_in);
      rd_hit = int_rd_en_in;
      base_sel = int_rd_base_addr_in;
      index_sel = int_rd_index_addr_in;
      #1;
      if (rd_hit === 1'b1)
      begin
        int_rd_base_data_out = int_reg_file[base_sel];
        int_rd_index_data_out = int_reg_file[index_sel];
      end
      else
      begin
        int_rd_base_data_out = ~int_rd_base_data_out;
        int_rd_index_data_out = ~int_rd_index_data_out;
      end
      // answer after the chosen number of waiting cycles, one-cycle ack
      if (mem_ack_out)
      begin
        mem_ack_out = 1'b0;
        wait_cnt = 2'h0;
      end
      else if (mem_req_in === 1'b1)
      begin
        if (wait_cnt == mem_wait_in)
          mem_ack_out = 1'b1;
        else
          wait_cnt = wait_cnt + 2'h1;
      end
      mem_data_out = mem_ack_out ? mem_word_in : ~mem_word_in;
      mem_align_err_out = mem_ack_out ? align_fault_in : ~align_fault_in;
      mem_dsi_err_out = mem_ack_out ? dsi_fault_in : ~dsi_fault_in;
    end
  end
endmodule : lfs_env_model

/* File: test_single_float_load_decode.sv */
`timescale 1ns/10ps
// directed and random loads; expectations go into a queue that a monitor drains in order
module test_single_float_load_decode;
  // expected event: 0 address, 1 float write, 2 base write, 3 fault, 4 illegal
  typedef struct {logic [2:0] kind; logic [63:0] val; logic [4:0] reg_no;} lfs_exp_t;
  lfs_exp_t    exp_q [$];   // oldest expectation first
  int          num_errors;  // mismatches seen
  int          n_tests;     // comparisons made
  logic        core_clk, srst, instr_valid, ready, illegal, rd_en, mem_req, mem_ack;
  logic        align_err, dsi_err, fw_en, iw_en, fault, fpscr_we, cr0_we;
  logic        align_fault, dsi_fault;
  logic [1:0]  mem_wait;
  logic [4:0]  rd_base_a, rd_idx_a, fw_addr, iw_addr;
  logic [31:0] instr, rd_base_d, rd_idx_d, mem_addr, mem_data, iw_data, mem_word, r;
  logic [63:0] fw_data;
  logic [31:0] odd [6] = '{32'h0000_0000, 32'hC020_0000, 32'h7F80_0000, 32'h7FC0_0001,
                           32'h0000_0001, 32'h807F_FFFF};

  lfs_decode dut (.core_clk_in(core_clk), .srst_in(srst), .instr_valid_in(instr_valid),
    .instr_in(instr), .ready_out(ready), .illegal_out(illegal), .int_rd_en_out(rd_en),
    .int_rd_base_addr_out(rd_base_a), .int_rd_index_addr_out(rd_idx_a),
    .int_rd_base_data_in(rd_base_d), .int_rd_index_data_in(rd_idx_d), .mem_req_out(mem_req),
    .mem_addr_out(mem_addr), .mem_ack_in(mem_ack), .mem_data_in(mem_data),
    .mem_align_err_in(align_err), .mem_dsi_err_in(dsi_err), .float_wr_en_out(fw_en),
    .float_wr_addr_out(fw_addr), .float_wr_data_out(fw_data), .int_wr_en_out(iw_en),
    .int_wr_addr_out(iw_addr), .int_wr_data_out(iw_data), .fault_out(fault),
    .fpscr_wr_en_out(fpscr_we), .cr0_wr_en_out(cr0_we));

  lfs_env_model model (.core_clk_in(core_clk), .int_rd_en_in(rd_en),
    .int_rd_base_addr_in(rd_base_a), .int_rd_index_addr_in(rd_idx_a),
    .int_rd_base_data_out(rd_base_d), .int_rd_index_data_out(rd_idx_d), .mem_req_in(mem_req),
    .mem_word_in(mem_word), .mem_wait_in(mem_wait), .align_fault_in(align_fault),
    .dsi_fault_in(dsi_fault), .mem_ack_out(mem_ack), .mem_data_out(mem_data),
    .mem_align_err_out(align_err), .mem_dsi_err_out(dsi_err));

  // 25 MHz
  always #20 core_clk = ~core_clk;

  task automatic check(input logic [71:0] exp, input logic [71:0] got, input string what);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // pairs one observed strobe with the oldest note
  task automatic take(input logic [2:0] kind, input logic [63:0] val, input logic [4:0] rno,
                      input string what);
    lfs_exp_t e;
    if (exp_q.size() == 0)
      check(72'h0, {kind, rno, val}, what);
    else
    begin
      e = exp_q.pop_front();
      check({e.kind, e.reg_no, e.val}, {kind, rno, val}, what);
    end
  endtask : take

  // exact widening, worked out independently of the design
  function automatic logic [63:0] widen(input logic [31:0] s);
    logic [10:0] e;
    logic [51:0] f;
    e = {3'h0, s[30:23]} + 11'h380;
    f = {s[22:0], 29'h0};
    if (s[30:23] == 8'hFF)
      e = 11'h7FF;
    else if (s[30:23] == 8'h00)
    begin
      e = (s[22:0] == 23'h0) ? 11'h000 : 11'h380;
      while (f != 52'h0 && !f[51])
      begin
        f = f << 1;
        e = e - 11'h001;
      end
      f = f << 1;
    end
    return {s[31], e, f};
  endfunction : widen

  // builds a load of one form with random target and offset fields
  function automatic logic [31:0] mk(input logic [1:0] form, input logic [4:0] ra);
    logic [31:0] q;
    q = $urandom();
    case (form)
      2'h0: mk = {6'h30, q[25:21], ra, q[15:0]};
      2'h1: mk = {6'h31, q[25:21], ra, q[15:0]};
      2'h2: mk = {6'h1F, q[25:21], ra, q[15:11], 10'h237, q[0]};
      default: mk = {6'h1F, q[25:21], ra, q[15:11], 10'h217, q[0]};
    endcase
  endfunction : mk

  // notes the outcome, offers one word, then waits until the decoder is free
  task automatic run_load(input logic [31:0] w, input logic [31:0] d, input logic [1:0] lat,
                          input logic [1:0] err);
    logic [31:0] bval, ea;
    logic        idx, legal, upd;
    int          n;
    idx = w[31:26] == 6'h1F && (w[10:1] == 10'h237 || w[10:1] == 10'h217);
    legal = idx || w[31:26] == 6'h30 || w[31:26] == 6'h31;
    upd = w[31:26] == 6'h31 || (idx && w[10:1] == 10'h237);
    bval = (w[20:16] == 5'h00) ? 32'h0 : model.int_reg_file[w[20:16]];
    ea = bval + (idx ? model.int_reg_file[w[15:11]] : {{16{w[15]}}, w[15:0]});
    if (!legal)
      exp_q.push_back('{3'h4, 64'h0, 5'h00});
    else
    begin
      exp_q.push_back('{3'h0, {32'h0, ea}, 5'h00});
      if (err != 2'h0)
        exp_q.push_back('{3'h3, 64'h0, 5'h00});
      else
        exp_q.push_back('{3'h1, widen(d), w[25:21]});
      if (err == 2'h0 && upd && w[20:16] != 5'h00)
        exp_q.push_back('{3'h2, {32'h0, ea}, w[20:16]});
    end
    mem_word = d;
    mem_wait = lat;
    {dsi_fault, align_fault} = err;
    @(posedge core_clk);
    #1;
    instr_valid = 1'b1;
    instr = w;
    @(posedge core_clk);
    #1;
    // a further load offered while busy must be ignored
    if (legal)
    begin
      instr = {6'h30, w[25:0]};
      repeat (2) @(posedge core_clk);
      #1;
    end
    instr_valid = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 40)
      check(72'h1, 72'h0, "ready return");
  endtask : run_load

  // monitor: every strobe is looked at mid-cycle, when it has settled
  always @(negedge core_clk)
  begin
    if (srst === 1'b0)
    begin
      check(72'h0, {70'h0, fpscr_we, cr0_we}, "status strobes");
      if (mem_req === 1'b1 && mem_ack === 1'b1)
        take(3'h0, {32'h0, mem_addr}, 5'h00, "address");
      if (fw_en === 1'b1) take(3'h1, fw_data, fw_addr, "float write");
      if (iw_en === 1'b1) take(3'h2, {32'h0, iw_data}, iw_addr, "base write");
      if (fault === 1'b1) take(3'h3, 64'h0, 5'h00, "fault");
      if (illegal === 1'b1) take(3'h4, 64'h0, 5'h00, "illegal");
    end
  end

  task automatic print_verdict();
    check(72'h0, {40'h0, exp_q.size()}, "missing events");
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // watchdog, several times the expected run length
  initial
  begin
    #(40 * 20000);
    check(72'h1, 72'h0, "watchdog");
    print_verdict();
  end

  initial
  begin
    {core_clk, instr_valid, instr, mem_word, mem_wait, align_fault, dsi_fault} = '0;
    srst = 1'b1;
    void'($urandom(79425));
    for (int i = 0; i < 32; i++) model.int_reg_file[i] = $urandom();
    repeat (8) @(posedge core_clk);
    #1;
    srst = 1'b0;
    check(72'h1, {71'h0, ready}, "ready after reset");
    // every form, base field zero and nonzero, loading single 1.0
    for (int f = 0; f < 8; f++)
      run_load(mk(f[1:0], f[2] ? 5'h00 : 5'h05),
               32'h3F80_0000, 2'h0, 2'h0);
    $display("test forms done");
    // zero, negative, infinity, nan, denormals
    foreach (odd[i]) run_load(mk(i[1:0], 5'h03), odd[i], 2'h1, 2'h0);
    $display("test values done");
    // align, storage and both faults across forms
    for (int e = 1; e < 4; e++)
      run_load(mk(e[1:0], 5'h07), 32'h4000_0000, 2'h2, e[1:0]);
    $display("test faults done");
    // random words, latencies and faults
    repeat (150)
    begin
      r = $urandom();
      run_load(r[2:0] > 3'h4 ? {6'h1F, r[31:6]} : mk(r[1:0], r[3] ? 5'h00 : r[8:4]), $urandom(),
               r[10:9], r[15:13] == 3'h0 ? r[12:11] : 2'h0);
    end
    $display("test random done");
    // the last strobes rise with ready; let the monitor take them before the queue is judged
    repeat (2) @(posedge core_clk);
    print_verdict();
  end
endmodule : test_single_float_load_decode
